// ===== hbp_host_port.sv
// Strapped host bus port: strap capture, clock divider and strobe-to-core access engine
//
// What this block does
// - Capture straps at reset release, then apply
// - Straps 110 select separate strobe bus mode
// - Strap 3 sets power-on general pin role
// - Strap 4 selects big or little endian
// - Strap 5 sets wait output polarity
// - Straps 7:6 divide input clock 1..4
// - Bus and memory clocks derive from input
// - 17-bit address in, 16-bit two-way data
// - Select input picks registers or buffer
// - Wait holds host until data ready/accepted
// - Accesses asynchronous to refresh, wait resolves
// - 128K window, 80K buffer in second block
`timescale 1ns/1ps
`default_nettype none
`include "hbp_params.svh"

module hbp_host_port (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Configuration straps
    input wire logic [`HBP_STRAP_W-1:0] config_strap,
    // Host bus
    input wire logic chip_select_n,
    input wire logic mem_reg_sel,
    input wire logic [`HBP_ADDR_W-1:0] host_address_in,
    input wire logic [`HBP_DATA_W-1:0] host_data_in,
    input wire logic read_n,
    input wire logic low_byte_write_n,
    input wire logic high_byte_write_n,
    input wire logic bus_start_n,
    input wire logic read_write_n,
    output logic [`HBP_DATA_W-1:0] host_data_out,
    output logic host_data_oe,
    output logic wait_out,
    // Configuration outputs
    output logic mode_ok,
    output logic gpio_input_role,
    output logic big_endian,
    output logic bus_clk_en,
    output logic mem_clk_en,
    // Core side (registers and display buffer)
    output logic core_req,
    output logic core_write,
    output logic core_mem,
    output logic [`HBP_ADDR_W-1:0] core_addr,
    output logic [`HBP_DATA_W-1:0] core_wdata,
    output logic [1:0] core_be,
    input wire logic core_ack,
    input wire logic [`HBP_DATA_W-1:0] core_rdata
);

    // ------------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------------
    logic [`HBP_STRAP_W-1:0] strap;
    logic strap_taken;

    // Straps are taken on the first edge after release; an async reset may only load constants
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap <= `HBP_STRAP_RST;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            strap <= config_strap;
            strap_taken <= 1'b1;
        end
    end

    // Decoded configuration, valid once the straps are held
    wire mode_sel = strap_taken && (strap[`HBP_MODE_HI:`HBP_MODE_LO] == `HBP_MODE_SEL);
    wire wait_lvl = strap[`HBP_WAITPOL_BIT];
    wire [1:0] div_sel = strap[`HBP_DIV_HI:`HBP_DIV_LO];

    // Configuration outputs registered from the held straps
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ok <= 1'b0;
            gpio_input_role <= 1'b0;
            big_endian <= 1'b0;
        end else begin
            mode_ok <= mode_sel;
            gpio_input_role <= strap_taken && strap[`HBP_GPIO_BIT];
            big_endian <= strap_taken && strap[`HBP_ENDIAN_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Bus and memory clock enables
    // ------------------------------------------------------------------------
    logic [1:0] div_cnt;
    wire div_wrap = (div_cnt == div_sel);

    // One enable pulse every div_sel+1 input clocks; memory clock runs at the bus rate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= 2'h0;
            bus_clk_en <= 1'b0;
            mem_clk_en <= 1'b0;
        end else begin
            div_cnt <= (div_wrap || !strap_taken) ? 2'h0 : div_cnt + 2'h1;
            bus_clk_en <= strap_taken && div_wrap;
            mem_clk_en <= strap_taken && div_wrap;
        end
    end

    // ------------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------------
    wire selected = mode_sel && !chip_select_n;
    wire wr_any = !low_byte_write_n || !high_byte_write_n;
    wire access = selected && (!read_n || wr_any);
    // Byte lanes swap when the bus runs little endian
    wire [`HBP_DATA_W-1:0] lane_data = strap[`HBP_ENDIAN_BIT] ? host_data_in
                                      : {host_data_in[7:0], host_data_in[15:8]};
    wire [1:0] lane_be = strap[`HBP_ENDIAN_BIT] ? {!high_byte_write_n, !low_byte_write_n}
                         : {!low_byte_write_n, !high_byte_write_n};
    wire [`HBP_DATA_W-1:0] lane_rd = strap[`HBP_ENDIAN_BIT] ? core_rdata
                                     : {core_rdata[7:0], core_rdata[15:8]};
    // Buffer addresses past the populated part answer without reaching the core
    wire in_range = !mem_reg_sel || (host_address_in < `HBP_BUF_LIMIT);
    wire ignore_bus = bus_start_n && read_write_n; // gates start: an access begins only while both are high

    // ------------------------------------------------------------------------
    // Access state machine
    // ------------------------------------------------------------------------
    hbp_pkg::hbp_state_t state, next_state;
    wire start = access && bus_clk_en && ignore_bus;

    // Next state: the core acknowledge arbitrates against refresh traffic
    always_comb begin
        next_state = state;
        case (state)
            hbp_pkg::HBP_IDLE: begin
                if (start) begin
                    next_state = in_range ? hbp_pkg::HBP_REQ : hbp_pkg::HBP_DONE;
                end
            end
            hbp_pkg::HBP_REQ: begin
                if (core_ack) begin
                    next_state = hbp_pkg::HBP_DONE;
                end
            end
            hbp_pkg::HBP_DONE: begin
                if (!access) begin
                    next_state = hbp_pkg::HBP_IDLE;
                end
            end
            default: next_state = hbp_pkg::HBP_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= hbp_pkg::HBP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Core request held from start until acknowledge, so no access is dropped mid-way
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_req <= 1'b0;
            core_write <= 1'b0;
            core_mem <= 1'b0;
            core_addr <= '0;
            core_wdata <= `HBP_DATA_RST;
            core_be <= 2'h0;
        end else if (state == hbp_pkg::HBP_IDLE && start) begin
            core_req <= in_range;
            core_write <= wr_any;
            core_mem <= mem_reg_sel;
            core_addr <= host_address_in;
            core_wdata <= lane_data;
            core_be <= wr_any ? lane_be : 2'h3;
        end else if (core_ack) begin
            core_req <= 1'b0;
        end
    end

    // Read data is captured on acknowledge and driven only while the read strobe stays low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_data_out <= `HBP_DATA_RST;
            host_data_oe <= 1'b0;
        end else begin
            if (state == hbp_pkg::HBP_REQ && core_ack) begin
                host_data_out <= lane_rd;
            end else if (state == hbp_pkg::HBP_IDLE && start) begin
                host_data_out <= `HBP_DATA_RST;
            end
            host_data_oe <= selected && !read_n && (next_state == hbp_pkg::HBP_DONE);
        end
    end

    // Wait held until the cycle completes, never while another device is addressed
    wire hold = access && (next_state != hbp_pkg::HBP_DONE);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_out <= 1'b1;
        end else begin
            wait_out <= (hold && selected) ? wait_lvl : !wait_lvl;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence cs_idle_s;
        strap_taken && chip_select_n;
    endsequence

    sequence ack_in_req_s;
        state == hbp_pkg::HBP_REQ && core_ack;
    endsequence

    strap_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        strap_taken |=> $stable(strap) && strap_taken)
        else $error("strap changed after capture");

    mode_dec_a: assert property (@(posedge clk) disable iff (!arst_n)
        strap_taken && strap[2:0] != 3'h6 |=> !mode_ok && !core_req)
        else $error("port active in wrong bus mode");

    gpio_role_a: assert property (@(posedge clk) disable iff (!arst_n)
        strap_taken |=> gpio_input_role == strap[3])
        else $error("gpio role does not follow strap");

    endian_a: assert property (@(posedge clk) disable iff (!arst_n)
        strap_taken |=> big_endian == strap[4])
        else $error("endian output does not follow strap");

    wait_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
        cs_idle_s |=> wait_out == !strap[5])
        else $error("wait active without chip select");

    div_pace_a: assert property (@(posedge clk) disable iff (!arst_n)
        strap_taken && bus_clk_en && strap[7:6] == 2'h1 |=> !bus_clk_en ##1 bus_clk_en)
        else $error("bus clock enable off ratio");

    wait_release_a: assert property (@(posedge clk) disable iff (!arst_n)
        ack_in_req_s ##0 !chip_select_n |=> wait_out == !strap[5])
        else $error("wait not released after acknowledge");

    req_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        core_req && !core_ack |=> core_req && $stable(core_addr))
        else $error("core request dropped before acknowledge");

    buf_range_a: assert property (@(posedge clk) disable iff (!arst_n)
        state == hbp_pkg::HBP_IDLE && start && mem_reg_sel
        && host_address_in >= 17'h1_4000 |=> !core_req)
        else $error("core reached beyond display buffer");

    rd_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
        host_data_oe |-> !$past(read_n) && !$past(chip_select_n))
        else $error("data driven outside a read");

endmodule

`default_nettype wire

// ===== hbp_params.svh
// Constants for the strapped host bus port: strap fields, decode values, bus widths and reset values
`ifndef HBP_PARAMS_SVH
`define HBP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Strap field positions
// ----------------------------------------------------------------------------
`define HBP_STRAP_W 8
`define HBP_MODE_HI 2
`define HBP_MODE_LO 0
`define HBP_GPIO_BIT 3
`define HBP_ENDIAN_BIT 4
`define HBP_WAITPOL_BIT 5
`define HBP_DIV_HI 7
`define HBP_DIV_LO 6

// ----------------------------------------------------------------------------
// Decode values, bus widths and reset values
// ----------------------------------------------------------------------------
`define HBP_MODE_SEL 3'h6
`define HBP_STRAP_RST 8'h00
`define HBP_ADDR_W 17
`define HBP_DATA_W 16
`define HBP_BUF_LIMIT 17'h1_4000
`define HBP_DATA_RST 16'h0000

`endif

// ===== hbp_pkg.sv
// Types shared by the strapped host bus port
`default_nettype none
package hbp_pkg;
    typedef enum logic [1:0] {
        HBP_IDLE,
        HBP_REQ,
        HBP_DONE
    } hbp_state_t;
endpackage
`default_nettype wire

// ===== hbp_host_model.sv
// Host processor model driving chip-select cycles into the port
`timescale 1ns/1ps
`default_nettype none
module hbp_host_model (
    // Clock, port outputs and wait polarity
    input wire logic clk,
    input wire logic wait_out,
    input wire logic wait_hi,
    input wire logic [15:0] host_data_out,
    // Host bus
    output logic chip_select_n,
    output logic mem_reg_sel,
    output logic [16:0] host_address_in,
    output logic [15:0] host_data_in,
    output logic read_n,
    output logic low_byte_write_n,
    output logic high_byte_write_n
);
    // Idle bus: select and strobes high
    initial begin
        {chip_select_n, read_n, low_byte_write_n, high_byte_write_n} = 4'hF;
        {mem_reg_sel, host_address_in, host_data_in} = 34'h0;
    end
    // One access, ended by the wait pin or by a fixed count of host wait states
    task automatic access(input logic mem, input logic [16:0] a, input logic wr,
            input logic [1:0] ln, input logic [15:0] wd, input int ws,
            output logic [15:0] rd, output logic ok, output logic held);
        int n;
        n = 0;
        ok = 1'b0;
        held = 1'b0;
        repeat (3) @(posedge clk);
        chip_select_n <= 1'b0;
        mem_reg_sel <= mem;
        host_address_in <= a;
        host_data_in <= wd;
        read_n <= wr;
        low_byte_write_n <= !(wr && ln[0]);
        high_byte_write_n <= !(wr && ln[1]);
        if (ws > 0) begin
            // Host counts its own wait states and ignores the wait pin
            repeat (ws) @(posedge clk);
            ok = 1'b1;
        end else begin
            // The registered wait pin reflects this cycle only from the second edge
            repeat (2) @(posedge clk);
            while (!ok && n < 64) begin
                if (wait_out === wait_hi) begin
                    held = 1'b1;
                    n++;
                    @(posedge clk);
                end else begin
                    ok = 1'b1;
                end
            end
        end
        rd = host_data_out;
        // Released lines must not keep showing the old value
        {chip_select_n, read_n, low_byte_write_n, high_byte_write_n} <= 4'hF;
        host_data_in <= ~wd;
        host_address_in <= ~a;
    endtask
endmodule
`default_nettype wire

// ===== hbp_tb_top.sv
// Self-checking bench for the strapped host bus port
`timescale 1ns/1ps
`default_nettype none
module strapped_host_bus_port_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] config_strap = 8'h00;
    logic chip_select_n, mem_reg_sel, read_n, low_byte_write_n, high_byte_write_n;
    logic [16:0] host_address_in, core_addr, c_addr;
    logic [15:0] host_data_in, host_data_out, core_wdata, c_wdata, rd;
    logic [15:0] core_rdata = 16'h0000;
    logic [15:0] rval = 16'h0000;
    logic [1:0] core_be, c_be;
    logic host_data_oe, wait_out, mode_ok, gpio_input_role, big_endian, ok, held;
    logic bus_clk_en, mem_clk_en, core_req, core_write, core_mem, c_write, c_mem;
    logic core_ack = 1'b0;
    int n_errors = 0, compares = 0, cycles = 0, n_req = 0, dly = 0, cnt = 0;

    always #12.5 clk = ~clk;
    hbp_host_port dut (.clk, .arst_n, .config_strap, .chip_select_n, .mem_reg_sel,
        .host_address_in, .host_data_in, .read_n, .low_byte_write_n, .high_byte_write_n,
        .bus_start_n(1'b1), .read_write_n(1'b1),
        .host_data_out, .host_data_oe, .wait_out, .mode_ok, .gpio_input_role, .big_endian,
        .bus_clk_en, .mem_clk_en, .core_req, .core_write, .core_mem, .core_addr,
        .core_wdata, .core_be, .core_ack, .core_rdata);
    hbp_host_model host (.clk, .wait_out, .wait_hi(config_strap[5]), .host_data_out,
        .chip_select_n, .mem_reg_sel, .host_address_in, .host_data_in, .read_n,
        .low_byte_write_n, .high_byte_write_n);

    // Core stand-in: slow answers mimic refresh conflicts, request is recorded
    always @(posedge clk) begin
        core_ack <= 1'b0;
        core_rdata <= ~core_rdata;
        if (core_req === 1'b1 && !core_ack) begin
            if (cnt == dly) begin
                core_ack <= 1'b1;
                core_rdata <= rval;
                {c_addr, c_wdata, c_be} <= {core_addr, core_wdata, core_be};
                {c_write, c_mem} <= {core_write, core_mem};
                n_req++;
                cnt <= 0;
            end else cnt <= cnt + 1;
        end
    end
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst(input logic [7:0] s);
        arst_n <= 1'b0;
        config_strap <= s;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    // Every divide code; pulses counted over 12 cycles
    task automatic t_ratio();
        int p;
        for (int k = 0; k < 4; k++) begin
            rst({k[1:0], 6'h1E});
            chk({mode_ok, gpio_input_role, big_endian, wait_out}, 4'hF);
            p = 0;
            repeat (12) begin
                @(posedge clk);
                if (bus_clk_en === 1'b1 && mem_clk_en === 1'b1) p++;
            end
            chk(17'(p), 17'(12 / (k + 1)));
        end
        $display("ratio test done");
    endtask
    task automatic t_write();
        int t0;
        rst(8'h3E);
        dly = 5;
        chk(wait_out, 1'b0);
        t0 = cycles;
        host.access(1'b0, 17'h1_2344, 1'b1, 2'b10, 16'hA55A, 0, rd, ok, held);
        chk({ok, held, cycles - t0 > 9}, 3'b111);
        chk(host_data_oe, 1'b0);
        chk({c_write, c_mem, c_be}, 4'b1010);
        chk(c_addr, 17'h1_2344);
        chk(c_wdata, 16'hA55A);
        $display("write test done");
    endtask
    task automatic t_read();
        for (int e = 0; e < 2; e++) begin
            rst(e ? 8'h1E : 8'h0E);
            dly = 9;
            rval = 16'h5AA5;
            host.access(1'b1, 17'h0_0100, 1'b0, 2'b00, 16'h0000, 0, rd, ok, held);
            chk({ok, held}, 2'b11);
            chk(host_data_oe, 1'b1);
            chk(rd, e ? 16'h5AA5 : 16'hA55A);
            chk({c_write, c_mem, c_be}, 4'b0111);
            repeat (2) @(posedge clk);
            chk(host_data_oe, 1'b0);
        end
        $display("read test done");
    endtask
    // Buffer edge, then a port strapped to another bus mode
    task automatic t_edge();
        int n0;
        rst(8'h1E);
        dly = 0;
        n0 = n_req;
        host.access(1'b1, 17'h1_4000, 1'b0, 2'b00, 16'h0000, 0, rd, ok, held);
        chk({ok, rd}, 17'h1_0000);
        chk(17'(n_req - n0), 17'h0_0000);
        host.access(1'b1, 17'h1_3FFE, 1'b1, 2'b11, 16'h1234, 0, rd, ok, held);
        chk(17'(n_req - n0), 17'h0_0001);
        rst(8'h00);
        chk({mode_ok, gpio_input_role, big_endian, wait_out}, 4'h1);
        host.access(1'b0, 17'h0_0010, 1'b1, 2'b11, 16'h0F0F, 0, rd, ok, held);
        chk({ok, held}, 2'b10);
        chk(17'(n_req - n0), 17'h0_0001);
        $display("edge test done");
    endtask
    // Host without the wait pin: fixed wait states for each divide ratio
    task automatic t_fixed();
        int ws;
        for (int k = 0; k < 4; k++) begin
            rst({k[1:0], 6'h1E});
            dly = 0;
            rval = 16'hC33C;
            ws = (k == 0) ? 4 : (k == 1) ? 6 : (k == 2) ? 10 : 12;
            host.access(1'b1, 17'h0_0200, 1'b0, 2'b00, 16'h0000, ws, rd, ok, held);
            chk({ok, rd}, 17'h1_C33C);
        end
        $display("fixed wait test done");
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        t_ratio();
        t_write();
        t_read();
        t_edge();
        t_fixed();
        end_of_test();
    end
endmodule
`default_nettype wire
